// file: acp_defines.vh
// Constants for the converter configuration port and pin straps
// What this block does
// - Shift serial bits only while enable is low, on serial clock falling edges.
// - Every sixteenth falling edge with enable low writes the word to its register.
// - Partial word at enable release is discarded without any write.
// - Several words in one enable low period each write their own register.
// - Word is five address bits then eleven data bits.
// - Serial clock up to 20 MHz works with an unbalanced duty cycle if each level lasts over one ref_clk period.
// - Link, serialize, edge, order, format follow registers only while override high.
// - Power-down pin high forces global power down, else register 0x00 D0 in serial use.
// - Coarse gain follows 0x0D D5 only with override high, else 0 dB in serial use.
// - Reference selection follows register 0x00 bit D5 in serial use.
// - Sync and deskew patterns follow 0x0A D5-D7 in serial use.
// - Pin-only: clock/data pins pick normal, sync, power down, deskew.
// - Pin-only: enable pin level picks reference and coarse gain.
// - Power-down pin at ground is normal, at supply is global power down.
// - First strap picks DDR one-wire, unused, SDR two-wire, DDR two-wire; the unused level decodes as DDR two-wire here.
// - Second strap picks 12x/14x serialization and, in SDR only, capture edge (DDR keeps falling edge).
// - Fourth strap picks bit order and data format.
// - Straps configure the device after power-up with no reset.
// - Reset pin pulse over 10 ns or self-clearing software reset bit.
// - Any reset clears every register bit to zero.
`ifndef ACP_DEFINES_VH
`define ACP_DEFINES_VH
`define ACP_WORD_BITS     16
`define ACP_CNT_W         4
`define ACP_CNT_LAST      4'hf
`define ACP_ADDR_MSB      15
`define ACP_ADDR_LSB      11
`define ACP_DATA_MSB      10
`define ACP_ADDR_W        5
`define ACP_DATA_W        11
`define ACP_REG_00        5'h00
`define ACP_REG_04        5'h04
`define ACP_REG_0A        5'h0a
`define ACP_REG_0B        5'h0b
`define ACP_REG_0C        5'h0c
`define ACP_REG_0D        5'h0d
`define ACP_REG_10        5'h10
`define ACP_REG_11        5'h11
`define ACP_DATA_ZERO     11'h000
`define ACP_B_SWRST       10
`define ACP_B_PDN_GLOBAL  0
`define ACP_B_REF         5
`define ACP_B_DF          9
`define ACP_PAT_MSB       7
`define ACP_PAT_LSB       5
`define ACP_PAT_DESKEW    3'h6
`define ACP_PAT_SYNC      3'h7
`define ACP_PAT_NORMAL    3'h0
`define ACP_B_PIN_OVERRIDE_FLAG        10
`define ACP_B_BYTEWISE    7
`define ACP_B_LSB_FIRST   6
`define ACP_B_COARSE      5
`define ACP_B_EDGE        4
`define ACP_B_SER14       2
`define ACP_B_SDR         1
`define ACP_B_TWO_WIRE    0
`define ACP_LVL_GND       2'h0
`define ACP_LVL_LOW       2'h1
`define ACP_LVL_HIGH      2'h2
`define ACP_LVL_SUPPLY    2'h3
`define ACP_CNT_ONE       4'h1
`define ACP_DATA_ONE      11'h001
`define ACP_CHPDN_MSB     4
`define ACP_CHPDN_LSB     1
`define ACP_CLKIN_MSB     6
`define ACP_CLKIN_LSB     2
`define ACP_FINE_MSB      10
`define ACP_FINE_LSB      8
`define ACP_B_CUSTOM_HI   0
`define ACP_PINS_SYNC     2'h1
`define ACP_PINS_PDN      2'h2
`define ACP_PINS_DESKEW   2'h3
`endif

// file: acp_sync2.v
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module acp_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         ref_clk,
    input  wire         sys_rst,
    // Levels
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule

// file: acp_config_port.v
// Configuration serial port, register bank and strap priority logic
`timescale 1ns/10ps
`include "acp_defines.vh"
module acp_config_port (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // Device pins
    input  wire        reset_pin,
    input  wire        port_enable_n,
    input  wire        port_serial_clk,
    input  wire        port_serial_in,
    input  wire [1:0]  port_enable_level,
    input  wire        power_down_pin,
    input  wire [1:0]  strap_link_select,
    input  wire [1:0]  strap_serialize_edge,
    input  wire [1:0]  strap_reserved,
    input  wire [1:0]  strap_order_format,
    // Resolved configuration
    output reg         cfg_global_pdn,
    output reg  [3:0]  cfg_chan_pdn,
    output reg         cfg_ext_ref,
    output reg         cfg_coarse_gain,
    output reg         cfg_two_wire,
    output reg         cfg_sdr,
    output reg         cfg_ser14,
    output reg         cfg_rise_edge,
    output reg         cfg_lsb_first,
    output reg         cfg_offset_bin,
    output reg         cfg_bytewise,
    output reg  [2:0]  cfg_pattern,
    output reg  [4:0]  cfg_clkin_gain,
    output reg  [11:0] cfg_custom,
    output reg  [2:0]  cfg_fine_gain,
    output reg  [10:0] cfg_term_word,
    output reg  [10:0] cfg_term_data,
    output reg         cfg_pin_mode,
    output reg         reg_write_pulse
);
    // All pins are asynchronous to ref_clk; the reserved strap is tied low and not used
    wire [10:0] pins_s;
    acp_sync2 #(.W(11)) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in ({reset_pin, port_enable_n, port_serial_clk, port_serial_in, power_down_pin,
                    strap_link_select, strap_serialize_edge, strap_order_format}),
        .sync_out (pins_s)
    );
    wire       rst_s  = pins_s[10];
    wire       en_n_s = pins_s[9];
    wire       sclk_s = pins_s[8];
    wire       sdi_s  = pins_s[7];
    wire       pdn_s  = pins_s[6];
    wire [1:0] lnk_s  = pins_s[5:4];
    wire [1:0] ser_s  = pins_s[3:2];
    wire [1:0] ord_s  = pins_s[1:0];
    // Enable level comes from a quantizer; only meaningful in pin mode
    wire [1:0] enl_s;
    acp_sync2 #(.W(2)) u_sync_en (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (port_enable_level),
        .sync_out (enl_s)
    );

    // Serial clock edge detect; 20 MHz sclk gives >= 3 ref clocks per level
    reg                    sclk_prev_q;
    reg [`ACP_CNT_W-1:0]   bit_cnt_q;
    reg [`ACP_CNT_W-1:0]   bit_cnt_d;
    reg [`ACP_WORD_BITS-2:0] shift_q;
    reg [`ACP_WORD_BITS-2:0] shift_d;
    reg                    wr_d;
    reg [`ACP_WORD_BITS-1:0] word_d;
    reg [`ACP_WORD_BITS-1:0] word_q;
    reg                    wr_q;
    wire sclk_fall = sclk_prev_q & ~sclk_s;

    always @* begin
        bit_cnt_d = bit_cnt_q;
        shift_d   = shift_q;
        wr_d      = 1'b0;
        word_d    = {shift_q, sdi_s};
        if (en_n_s) begin
            bit_cnt_d = {`ACP_CNT_W{1'b0}};
        end else if (sclk_fall) begin
            shift_d   = {shift_q[`ACP_WORD_BITS-3:0], sdi_s};
            bit_cnt_d = bit_cnt_q + `ACP_CNT_ONE;
            if (bit_cnt_q == `ACP_CNT_LAST) begin
                wr_d = 1'b1;
            end
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_prev_q <= 1'b0;
            bit_cnt_q   <= {`ACP_CNT_W{1'b0}};
            shift_q     <= {(`ACP_WORD_BITS-1){1'b0}};
            word_q      <= {`ACP_WORD_BITS{1'b0}};
            wr_q        <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            bit_cnt_q   <= bit_cnt_d;
            shift_q     <= shift_d;
            wr_q        <= wr_d;
            if (wr_d) begin
                word_q <= word_d;
            end
        end
    end

    // Register bank
    wire [`ACP_ADDR_W-1:0] wa = word_q[`ACP_ADDR_MSB:`ACP_ADDR_LSB];
    wire [`ACP_DATA_W-1:0] wd = word_q[`ACP_DATA_MSB:0];
    reg  [`ACP_DATA_W-1:0] r00_q, r04_q, r0a_q, r0b_q, r0c_q, r0d_q, r10_q, r11_q;
    reg                    swrst_q;
    // Reset pin held high means pin-only mode, so it cannot clear registers level-wise
    reg                    rst_prev_q;
    wire                   rst_rise = rst_s & ~rst_prev_q;
    wire                   clr = rst_rise | swrst_q;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_prev_q <= 1'b0;
            swrst_q    <= 1'b0;
            r00_q      <= `ACP_DATA_ZERO;
            r04_q      <= `ACP_DATA_ZERO;
            r0a_q      <= `ACP_DATA_ZERO;
            r0b_q      <= `ACP_DATA_ZERO;
            r0c_q      <= `ACP_DATA_ZERO;
            r0d_q      <= `ACP_DATA_ZERO;
            r10_q      <= `ACP_DATA_ZERO;
            r11_q      <= `ACP_DATA_ZERO;
        end else begin
            rst_prev_q <= rst_s;
            swrst_q    <= 1'b0;
            if (clr) begin
                r00_q <= `ACP_DATA_ZERO;
                r04_q <= `ACP_DATA_ZERO;
                r0a_q <= `ACP_DATA_ZERO;
                r0b_q <= `ACP_DATA_ZERO;
                r0c_q <= `ACP_DATA_ZERO;
                r0d_q <= `ACP_DATA_ZERO;
                r10_q <= `ACP_DATA_ZERO;
                r11_q <= `ACP_DATA_ZERO;
            end else if (wr_q) begin
                case (wa)
                    `ACP_REG_00: begin
                        // Reset bit self-clears: it only triggers the clear
                        r00_q   <= wd & ~(`ACP_DATA_ONE << `ACP_B_SWRST);
                        swrst_q <= wd[`ACP_B_SWRST];
                    end
                    `ACP_REG_04: r04_q <= wd;
                    `ACP_REG_0A: r0a_q <= wd;
                    `ACP_REG_0B: r0b_q <= wd;
                    `ACP_REG_0C: r0c_q <= wd;
                    `ACP_REG_0D: r0d_q <= wd;
                    `ACP_REG_10: r10_q <= wd;
                    `ACP_REG_11: r11_q <= wd;
                    default: r00_q <= r00_q;
                endcase
            end
        end
    end

    // Level code decoding
    function lvl_is;
        input [1:0] lvl;
        input [1:0] want;
        begin
            lvl_is = (lvl == want);
        end
    endfunction

    wire pin_override_flag     = r0d_q[`ACP_B_PIN_OVERRIDE_FLAG];
    wire pin_mode = rst_s;
    reg  [1:0] mode_pins_d;
    reg        s_two_wire, s_sdr, s_ser14, s_rise, s_lsb, s_offb;

    // Strap decode; straps are always live so no reset is needed after power-up
    always @* begin
        s_two_wire = ~lvl_is(lnk_s, `ACP_LVL_GND);
        s_sdr      = lvl_is(lnk_s, `ACP_LVL_HIGH);
        s_ser14    = lvl_is(ser_s, `ACP_LVL_LOW) | lvl_is(ser_s, `ACP_LVL_HIGH);
        s_rise     = lvl_is(ser_s, `ACP_LVL_HIGH) | lvl_is(ser_s, `ACP_LVL_SUPPLY);
        s_lsb      = lvl_is(ord_s, `ACP_LVL_HIGH) | lvl_is(ord_s, `ACP_LVL_SUPPLY);
        s_offb     = lvl_is(ord_s, `ACP_LVL_LOW) | lvl_is(ord_s, `ACP_LVL_HIGH);
        mode_pins_d = {sclk_s, sdi_s};
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_global_pdn  <= 1'b0;
            cfg_chan_pdn    <= 4'h0;
            cfg_ext_ref     <= 1'b0;
            cfg_coarse_gain <= 1'b0;
            cfg_two_wire    <= 1'b0;
            cfg_sdr         <= 1'b0;
            cfg_ser14       <= 1'b0;
            cfg_rise_edge   <= 1'b0;
            cfg_lsb_first   <= 1'b0;
            cfg_offset_bin  <= 1'b0;
            cfg_bytewise    <= 1'b0;
            cfg_pattern     <= `ACP_PAT_NORMAL;
            cfg_clkin_gain  <= 5'h00;
            cfg_custom      <= 12'h000;
            cfg_fine_gain   <= 3'h0;
            cfg_term_word   <= 11'h000;
            cfg_term_data   <= 11'h000;
            cfg_pin_mode    <= 1'b0;
            reg_write_pulse <= 1'b0;
        end else begin
            cfg_pin_mode    <= pin_mode;
            reg_write_pulse <= wr_q;
            cfg_chan_pdn    <= r00_q[`ACP_CHPDN_MSB:`ACP_CHPDN_LSB];
            cfg_clkin_gain  <= r04_q[`ACP_CLKIN_MSB:`ACP_CLKIN_LSB];
            cfg_custom      <= {r0c_q[`ACP_B_CUSTOM_HI], r0b_q};
            cfg_fine_gain   <= r0c_q[`ACP_FINE_MSB:`ACP_FINE_LSB];
            cfg_term_word   <= r10_q;
            cfg_term_data   <= r11_q;
            if (pin_override_flag) begin
                cfg_two_wire   <= r0d_q[`ACP_B_TWO_WIRE];
                cfg_sdr        <= r0d_q[`ACP_B_SDR];
                cfg_ser14      <= r0d_q[`ACP_B_SER14];
                cfg_rise_edge  <= r0d_q[`ACP_B_EDGE];
                cfg_lsb_first  <= r0d_q[`ACP_B_LSB_FIRST];
                cfg_bytewise   <= r0d_q[`ACP_B_BYTEWISE];
                cfg_offset_bin <= r0a_q[`ACP_B_DF];
            end else begin
                cfg_two_wire   <= s_two_wire;
                cfg_sdr        <= s_sdr;
                cfg_ser14      <= s_ser14;
                cfg_rise_edge  <= s_rise & s_sdr;
                cfg_lsb_first  <= s_lsb;
                cfg_bytewise   <= 1'b0;
                cfg_offset_bin <= s_offb;
            end
            if (pin_mode) begin
                // Serial pins act as straps here
                cfg_global_pdn  <= pdn_s | (mode_pins_d == `ACP_PINS_PDN);
                cfg_pattern     <= (mode_pins_d == `ACP_PINS_SYNC) ? `ACP_PAT_SYNC :
                                   (mode_pins_d == `ACP_PINS_DESKEW) ? `ACP_PAT_DESKEW : `ACP_PAT_NORMAL;
                cfg_ext_ref     <= lvl_is(enl_s, `ACP_LVL_GND) | lvl_is(enl_s, `ACP_LVL_LOW);
                cfg_coarse_gain <= lvl_is(enl_s, `ACP_LVL_LOW) | lvl_is(enl_s, `ACP_LVL_HIGH);
            end else begin
                cfg_global_pdn  <= pdn_s | r00_q[`ACP_B_PDN_GLOBAL];
                cfg_pattern     <= r0a_q[`ACP_PAT_MSB:`ACP_PAT_LSB];
                cfg_ext_ref     <= r00_q[`ACP_B_REF];
                cfg_coarse_gain <= pin_override_flag & r0d_q[`ACP_B_COARSE];
            end
        end
    end
endmodule

// file: acp_host_model.sv
// Host controller model for the serial configuration port
`timescale 1ns/10ps
module acp_host_model (
    // Serial port pins
    output logic port_enable_n,
    output logic port_serial_clk,
    output logic port_serial_in
);
    initial begin
        port_enable_n   = 1'b1;
        port_serial_clk = 1'b0;
        port_serial_in  = 1'b0;
    end
    // Static levels while the pins act as straps
    task pins(input logic en_n, input logic clk, input logic din);
        port_enable_n   = en_n;
        port_serial_clk = clk;
        port_serial_in  = din;
    endtask
    // MSB first; 32/48 ns split exercises an unbalanced duty cycle
    task xfer(input logic [47:0] w, input int n);
        port_enable_n = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            port_serial_in  = w[i];
            port_serial_clk = 1'b1;
            #32 port_serial_clk = 1'b0;
            #48;
        end
        port_enable_n  = 1'b1;
        // Released data line shows no stale value
        port_serial_in = ~port_serial_in;
    endtask
endmodule

// file: acp_config_port_checker.sv
// Assertions on the configuration port
`timescale 1ns/10ps
module acp_config_port_checker (
    input wire       ref_clk,
    input wire       sys_rst,
    input wire       reset_pin,
    input wire       port_enable_n,
    input wire       port_serial_clk,
    input wire       port_serial_in,
    input wire [1:0] port_enable_level,
    input wire       power_down_pin,
    input wire [1:0] strap_link_select,
    input wire [1:0] strap_order_format,
    input wire       cfg_global_pdn,
    input wire       cfg_ext_ref,
    input wire       cfg_coarse_gain,
    input wire       cfg_two_wire,
    input wire       cfg_sdr,
    input wire       cfg_lsb_first,
    input wire       cfg_offset_bin,
    input wire [2:0] cfg_pattern,
    input wire       cfg_pin_mode,
    input wire       reg_write_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Six cycles cover two sync stages plus output register
    AST_PDN_FORCED: assert property (power_down_pin [*6] |-> cfg_global_pdn)
        else $error("pdn pin did not force power down");
    AST_PIN_MODE: assert property (reset_pin [*6] |-> cfg_pin_mode)
        else $error("pin mode missing");
    AST_PULSE_GAP: assert property (reg_write_pulse |=> !reg_write_pulse [*8])
        else $error("write pulse too long or too close");
    AST_PULSE_EN: assert property (reg_write_pulse |-> !$past(port_enable_n, 8))
        else $error("write without enable low");
    AST_PIN_SYNC: assert property ((reset_pin && !port_serial_clk && port_serial_in) [*6]
        |-> cfg_pattern == 3'h7)
        else $error("sync pattern not selected");
    AST_PIN_REF: assert property ((reset_pin && port_enable_level == 2'h1) [*6]
        |-> cfg_ext_ref && cfg_coarse_gain)
        else $error("enable level decode wrong");
    AST_PIN_LINK: assert property ((reset_pin && strap_link_select == 2'h2) [*6]
        |-> cfg_sdr && cfg_two_wire)
        else $error("link strap decode wrong");
    AST_PIN_ORDER: assert property ((reset_pin && strap_order_format == 2'h2) [*6]
        |-> cfg_lsb_first && cfg_offset_bin)
        else $error("order strap decode wrong");
    cover property (reg_write_pulse);
    cover property (cfg_pin_mode && cfg_pattern == 3'h6);
    cover property (cfg_global_pdn && !cfg_pin_mode);
endmodule

// file: testbench.sv
// Self-checking bench for the configuration port
`timescale 1ns/10ps
module testbench;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reset_pin = 1'b1;
    logic [1:0]  port_enable_level = 2'h0;
    logic        power_down_pin = 1'b0;
    logic [1:0]  strap_link_select = 2'h0;
    logic [1:0]  strap_serialize_edge = 2'h0;
    logic [1:0]  strap_reserved = 2'h0;
    logic [1:0]  strap_order_format = 2'h0;
    wire         port_enable_n, port_serial_clk, port_serial_in;
    wire         cfg_global_pdn, cfg_ext_ref, cfg_coarse_gain, cfg_two_wire, cfg_sdr, cfg_ser14;
    wire         cfg_rise_edge, cfg_lsb_first, cfg_offset_bin, cfg_bytewise, cfg_pin_mode, reg_write_pulse;
    wire [2:0]   cfg_pattern, cfg_fine_gain;
    wire [3:0]   cfg_chan_pdn;
    wire [4:0]   cfg_clkin_gain;
    wire [11:0]  cfg_custom;
    wire [10:0]  cfg_term_word, cfg_term_data;
    int          n_errors = 0;
    int          n_compared = 0;
    int          n_pulses = 0;
    // Decode tables, entry i at bits [i*w +: w]
    localparam logic [11:0] PAT = 12'hc38;
    localparam logic [7:0]  REFT = 8'h1e;
    localparam logic [7:0]  LINK = 8'h74;
    localparam logic [7:0]  ORD = 8'hb4;
    localparam logic [7:0]  EDGE = 8'h78;
    acp_config_port acp_config_port_inst (.*);
    acp_host_model acp_host_model_inst (.*);
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (reg_write_pulse === 1'b1) n_pulses++;
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    function automatic logic [15:0] snap();
        return {3'h0, cfg_global_pdn, cfg_ext_ref, cfg_coarse_gain, cfg_two_wire, cfg_sdr, cfg_ser14,
                cfg_rise_edge, cfg_lsb_first, cfg_offset_bin, cfg_bytewise, cfg_pattern};
    endfunction
    task wr(input logic [4:0] a, input logic [10:0] d);
        acp_host_model_inst.xfer({32'h0, a, d}, 16);
        w(12);
    endtask
    // Straps decoded from power-up with reset pin held high
    task t_pin_straps();
        for (int i = 0; i < 4; i++) begin
            acp_host_model_inst.pins(1'b1, i[1], i[0]);
            {port_enable_level, strap_link_select, strap_order_format} = {3{i[1:0]}};
            w(8);
            chk("pin mode", 16'h1, {15'h0, cfg_pin_mode});
            chk("pdn", {15'h0, i == 2}, {15'h0, cfg_global_pdn});
            chk("pattern", {13'h0, PAT[i*3+:3]}, {13'h0, cfg_pattern});
            chk("ref gain", {14'h0, REFT[i*2+:2]}, {14'h0, cfg_ext_ref, cfg_coarse_gain});
            chk("link", {14'h0, LINK[i*2+:2]}, {14'h0, cfg_sdr, cfg_two_wire});
            chk("order", {14'h0, ORD[i*2+:2]}, {14'h0, cfg_lsb_first, cfg_offset_bin});
        end
    endtask
    task t_pin_edge();
        strap_link_select = 2'h2;
        for (int i = 0; i < 4; i++) begin
            strap_serialize_edge = i[1:0];
            w(8);
            chk("ser edge", {14'h0, EDGE[i*2+:2]}, {14'h0, cfg_ser14, cfg_rise_edge});
        end
        // DDR bit clock keeps the falling capture edge
        strap_link_select = 2'h3;
        w(8);
        chk("ddr edge", 16'h0000, {14'h0, cfg_ser14, cfg_rise_edge});
    endtask
    // Pulse the reset pin, then hold it low with straps grounded
    task t_serial_words();
        {port_enable_level, strap_link_select, strap_serialize_edge, strap_order_format} = 8'h00;
        acp_host_model_inst.pins(1'b1, 1'b0, 1'b0);
        reset_pin = 1'b0;
        w(4);
        reset_pin = 1'b1;
        w(2);
        reset_pin = 1'b0;
        w(10);
        chk("after reset", 16'h0000, snap());
        acp_host_model_inst.xfer({5'h0d, 11'h4f7, 5'h0a, 11'h2e0, 5'h0b, 11'h555}, 48);
        w(12);
        chk("override on", 16'h07ff, snap());
        chk("custom", 16'h0555, {4'h0, cfg_custom});
    endtask
    task t_pdn_ref();
        wr(5'h00, 11'h021);
        chk("pdn ref", 16'h1fff, snap());
        wr(5'h00, 11'h020);
        chk("pdn off", 16'h0fff, snap());
        power_down_pin = 1'b1;
        w(8);
        chk("pdn pin", 16'h1fff, snap());
        power_down_pin = 1'b0;
        w(8);
    endtask
    task t_refused();
        acp_host_model_inst.xfer({38'h0, 5'h0a, 5'h00}, 10);
        w(12);
        chk("partial", 16'h0fff, snap());
        chk("pulses", 16'h5, n_pulses[15:0]);
        wr(5'h1f, 11'h7ff);
        chk("unmapped", 16'h0fff, snap());
    endtask
    // Hardware reset from a programmed state, then the wide fields
    task t_wide_regs();
        reset_pin = 1'b1;
        w(2);
        reset_pin = 1'b0;
        w(10);
        chk("hw reset", 16'h0000, snap());
        chk("hw custom", 16'h0000, {4'h0, cfg_custom});
        wr(5'h00, 11'h03e);
        wr(5'h04, 11'h028);
        wr(5'h0a, 11'h2e0);
        wr(5'h0c, 11'h501);
        wr(5'h10, 11'h2aa);
        wr(5'h11, 11'h7ff);
        chk("chan pdn", 16'h000f, {12'h0, cfg_chan_pdn});
        chk("clkin fine", 16'h0055, {8'h0, cfg_clkin_gain, cfg_fine_gain});
        chk("custom b", 16'h0800, {4'h0, cfg_custom});
        chk("term word", 16'h02aa, {5'h0, cfg_term_word});
        chk("term data", 16'h07ff, {5'h0, cfg_term_data});
    endtask
    task t_pin_override_flag_off_swrst();
        wr(5'h0d, 11'h020);
        chk("override off", 16'h0807, snap());
        wr(5'h00, 11'h400);
        chk("soft reset", 16'h0000, snap());
        chk("custom clr", 16'h0000, {4'h0, cfg_custom});
        chk("wide clr", 16'h0000, {cfg_clkin_gain, cfg_fine_gain, cfg_chan_pdn, 4'h0});
        chk("term clr", 16'h0000, {5'h0, cfg_term_word | cfg_term_data});
        chk("pulses", 16'he, n_pulses[15:0]);
    endtask
    task print_verdict();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        $display("ERROR watchdog expected done seen hang");
        n_errors++;
        print_verdict();
    end
    initial begin
        w(6);
        sys_rst = 1'b0;
        t_pin_straps();
        t_pin_edge();
        t_serial_words();
        t_pdn_ref();
        t_refused();
        t_wide_regs();
        t_pin_override_flag_off_swrst();
        print_verdict();
    end
endmodule
bind acp_config_port acp_config_port_checker acp_config_port_checker_inst (.*);
